/* File: shared/ulfc_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef ULFC_MAP_SVH
`define ULFC_MAP_SVH
`define ULFC_LCR_OFF 8'h00
`define ULFC_DATA_OFF 8'h04
`define ULFC_STAT_OFF 8'h08
`define ULFC_LCR_RST 8'h00
`define ULFC_BRK_BIT 0
`define ULFC_PEN_BIT 1
`define ULFC_EPS_BIT 2
`define ULFC_TWO_STOP_SEL_BIT 3
`define ULFC_FEN_BIT 4
`define ULFC_WL_LO 5
`define ULFC_WL_HI 6
`define ULFC_SPS_BIT 7
`define ULFC_CLK_HZ 50000000
`define ULFC_BAUD 115200
`define ULFC_BIT_CYC (`ULFC_CLK_HZ / `ULFC_BAUD)
`define ULFC_FIFO_DEPTH 32
`endif

/* File: shared/ulfc_pkg.sv */
// state types of the line-format transmitter and receiver
package ulfc_pkg;
	typedef enum logic [2:0] {
		TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK
	} ulfc_tx_st_t;
	typedef enum logic [2:0] {
		RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
	} ulfc_rx_st_t;
endpackage

/* File: core/ulfc_fifo.sv */
// character queue with a settable depth limit
`timescale 1ns/10ps
module ulfc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW = $clog2(DEPTH)
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// control
	input wire logic flush,
	input wire logic [AW:0] limit,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [AW:0] level
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0] cnt_q;
	logic do_in;
	logic do_out;

	assign in_ready = (cnt_q < limit);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem[rp_q];
	assign level = cnt_q;
	assign do_in = in_valid && in_ready;
	assign do_out = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (do_in) begin
			mem[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (flush) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			if (do_in) begin
				wp_q <= wp_q + 1'b1;
			end
			if (do_out) begin
				rp_q <= rp_q + 1'b1;
			end
			if (do_in && !do_out) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (do_out && !do_in) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // ulfc_fifo

/* File: core/ulfc_top.sv */
// serial line-format control with queued transmit and receive
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "ulfc_map.svh"
//
// Contract
// - word length field selects five, six, seven or eight data bits
// - stick parity sends and checks a fixed bit: 0 if even, else 1
// - fifo mode on: transmit and receive queue many characters
// - fifo mode off: each direction holds a single character
// - two stop select makes the transmitter send two stop bits
// - receiver checks only one stop bit regardless of setting
// - even parity: data plus parity hold an even count of ones
// - odd parity: data plus parity hold an odd count of ones
// - even select is ignored while parity is off
// - parity on: parity bit sent and received bit checked
// - parity off: no parity bit sent, none checked
// - send break finishes current character, then holds line low
module ulfc_top #(
	parameter int BIT_CYC = `ULFC_BIT_CYC,
	parameter int DEPTH = `ULFC_FIFO_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// serial line
	input wire logic serial_rx_in,
	output logic serial_tx_out
);
	import ulfc_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [15:0] BIT_END = 16'(BIT_CYC - 1);
	localparam logic [15:0] HALF_END = 16'(BIT_CYC / 2 - 1);

	////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] word_mask(input logic [1:0] wl);
		case (wl)
			2'h3: word_mask = 8'hFF;
			2'h2: word_mask = 8'h7F;
			2'h1: word_mask = 8'h3F;
			default: word_mask = 8'h1F;
		endcase
	endfunction

	function automatic logic par_bit(input logic [7:0] d,
		input logic [1:0] wl, input logic even, input logic stick);
		if (stick) begin
			par_bit = ~even;
		end else if (even) begin
			par_bit = ^(d & word_mask(wl));
		end else begin
			par_bit = ~^(d & word_mask(wl));
		end
	endfunction

	////////////////////////////////////////////////////////////////////
	// line control register
	logic [7:0] lcr_q;
	logic send_break;
	logic parity_on;
	logic even_parity_sel;
	logic two_stop_sel;
	logic fifo_mode_on;
	logic [1:0] word_length_sel;
	logic stick_parity_sel;
	logic wr_lcr;
	logic wr_data;
	logic wr_stat;
	logic rd_data;
	logic fifo_flush;
	logic [AW:0] fifo_limit;

	assign send_break = lcr_q[`ULFC_BRK_BIT];
	assign parity_on = lcr_q[`ULFC_PEN_BIT];
	assign even_parity_sel = lcr_q[`ULFC_EPS_BIT];
	assign two_stop_sel = lcr_q[`ULFC_TWO_STOP_SEL_BIT];
	assign fifo_mode_on = lcr_q[`ULFC_FEN_BIT];
	assign word_length_sel = lcr_q[`ULFC_WL_HI:`ULFC_WL_LO];
	assign stick_parity_sel = lcr_q[`ULFC_SPS_BIT];
	assign wr_lcr = reg_wr && (reg_addr == `ULFC_LCR_OFF);
	assign wr_data = reg_wr && (reg_addr == `ULFC_DATA_OFF);
	assign wr_stat = reg_wr && (reg_addr == `ULFC_STAT_OFF);
	assign rd_data = reg_rd && (reg_addr == `ULFC_DATA_OFF);
	// switching fifo mode empties both queues so no stale word survives
	assign fifo_flush = wr_lcr &&
		(reg_wdata[`ULFC_FEN_BIT] != fifo_mode_on);
	// character mode keeps one slot; fifo mode the full depth
	assign fifo_limit = fifo_mode_on ? (AW+1)'(DEPTH) : (AW+1)'(1);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lcr_q <= `ULFC_LCR_RST;
		end else if (wr_lcr) begin
			lcr_q <= reg_wdata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// queues
	logic tx_pop_valid;
	logic tx_pop_ready;
	logic [7:0] tx_pop_data;
	logic tx_push_ready;
	logic [AW:0] tx_level;
	logic rx_push_q;
	logic [7:0] rx_word_q;
	logic rx_push_ready;
	logic rx_pop_valid;
	logic [7:0] rx_pop_data;
	logic [AW:0] rx_level;

	ulfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.flush(fifo_flush),
		.limit(fifo_limit),
		.in_valid(wr_data),
		.in_ready(tx_push_ready),
		.in_data(reg_wdata[7:0]),
		.out_valid(tx_pop_valid),
		.out_ready(tx_pop_ready),
		.out_data(tx_pop_data),
		.level(tx_level)
	);

	ulfc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.flush(fifo_flush),
		.limit(fifo_limit),
		.in_valid(rx_push_q),
		.in_ready(rx_push_ready),
		.in_data(rx_word_q),
		.out_valid(rx_pop_valid),
		.out_ready(rd_data),
		.out_data(rx_pop_data),
		.level(rx_level)
	);

	////////////////////////////////////////////////////////////////////
	// transmitter
	ulfc_tx_st_t tx_st_q;
	logic [15:0] tx_cnt_q;
	logic [2:0] tx_idx_q;
	logic tx_stop2_q;
	logic [7:0] tx_word_q;
	logic tx_tick;
	logic tx_last;
	logic tx_d;

	assign tx_tick = (tx_cnt_q == BIT_END);
	assign tx_last = (tx_idx_q == 3'(4 + word_length_sel));
	// new characters only leave the queue between frames, so break waits
	assign tx_pop_ready = (tx_st_q == TX_IDLE) && !send_break;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_cnt_q <= '0;
		end else if (tx_tick || tx_st_q == TX_IDLE || tx_st_q == TX_BRK) begin
			tx_cnt_q <= '0;
		end else begin
			tx_cnt_q <= tx_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_st_q <= TX_IDLE;
			tx_idx_q <= '0;
			tx_stop2_q <= 1'b0;
			tx_word_q <= '0;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					tx_idx_q <= '0;
					tx_stop2_q <= 1'b0;
					if (send_break) begin
						tx_st_q <= TX_BRK;
					end else if (tx_pop_valid) begin
						tx_word_q <= tx_pop_data;
						tx_st_q <= TX_START;
					end
				end
				TX_START: begin
					if (tx_tick) begin
						tx_st_q <= TX_DATA;
					end
				end
				TX_DATA: begin
					if (tx_tick) begin
						tx_idx_q <= tx_idx_q + 3'h1;
						if (tx_last) begin
							tx_st_q <= parity_on ? TX_PAR : TX_STOP;
						end
					end
				end
				TX_PAR: begin
					if (tx_tick) begin
						tx_st_q <= TX_STOP;
					end
				end
				TX_STOP: begin
					if (tx_tick) begin
						if (two_stop_sel && !tx_stop2_q) begin
							tx_stop2_q <= 1'b1;
						end else begin
							tx_st_q <= TX_IDLE;
						end
					end
				end
				TX_BRK: begin
					if (!send_break) begin
						tx_st_q <= TX_IDLE;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end

	always_comb begin
		case (tx_st_q)
			TX_START: tx_d = 1'b0;
			TX_DATA: tx_d = tx_word_q[tx_idx_q];
			TX_PAR: tx_d = par_bit(tx_word_q, word_length_sel,
				even_parity_sel, stick_parity_sel);
			TX_BRK: tx_d = 1'b0;
			default: tx_d = 1'b1;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			serial_tx_out <= 1'b1;
		end else begin
			serial_tx_out <= tx_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// receiver
	logic rx_s1_q;
	logic rx_s2_q;
	ulfc_rx_st_t rx_st_q;
	logic [15:0] rx_cnt_q;
	logic [2:0] rx_idx_q;
	logic [7:0] rx_sh_q;
	logic rx_tick;
	logic rx_half;
	logic rx_last;
	logic [7:0] rx_aligned;
	logic perr_set;
	logic ferr_set;
	logic ovr_set;

	assign rx_tick = (rx_cnt_q == BIT_END);
	assign rx_half = (rx_cnt_q == HALF_END);
	assign rx_last = (rx_idx_q == 3'(4 + word_length_sel));
	// bits arrive lsb first at the top, so narrow words sit high
	assign rx_aligned = rx_sh_q >> (2'h3 - word_length_sel);
	assign perr_set = (rx_st_q == RX_PAR) && rx_tick &&
		(rx_s2_q != par_bit(rx_aligned, word_length_sel,
		even_parity_sel, stick_parity_sel));
	assign ferr_set = (rx_st_q == RX_STOP) && rx_tick && !rx_s2_q;
	assign ovr_set = rx_push_q && !rx_push_ready;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_rx_in;
			rx_s2_q <= rx_s1_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_cnt_q <= '0;
		end else if (rx_st_q == RX_IDLE || rx_tick ||
			(rx_st_q == RX_START && rx_half)) begin
			rx_cnt_q <= '0;
		end else begin
			rx_cnt_q <= rx_cnt_q + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_st_q <= RX_IDLE;
			rx_idx_q <= '0;
			rx_sh_q <= '0;
			rx_word_q <= '0;
			rx_push_q <= 1'b0;
		end else begin
			rx_push_q <= 1'b0;
			case (rx_st_q)
				RX_IDLE: begin
					rx_idx_q <= '0;
					if (!rx_s2_q) begin
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					if (rx_half) begin
						rx_st_q <= rx_s2_q ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
						rx_idx_q <= rx_idx_q + 3'h1;
						if (rx_last) begin
							rx_st_q <= parity_on ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (rx_tick) begin
						rx_st_q <= RX_STOP;
					end
				end
				RX_STOP: begin
					// a second stop bit is never looked for
					if (rx_tick) begin
						rx_st_q <= RX_IDLE;
						rx_push_q <= rx_s2_q;
						rx_word_q <= rx_aligned & word_mask(word_length_sel);
					end
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// status flags: a hardware set beats a same-cycle software clear
	logic perr_q;
	logic ferr_q;
	logic ovr_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			perr_q <= 1'b0;
			ferr_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			perr_q <= perr_set || (perr_q && !(wr_stat && reg_wdata[5]));
			ferr_q <= ferr_set || (ferr_q && !(wr_stat && reg_wdata[6]));
			ovr_q <= ovr_set || (ovr_q && !(wr_stat && reg_wdata[7]));
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				`ULFC_LCR_OFF: reg_rdata <= {24'h000000, lcr_q};
				`ULFC_DATA_OFF: reg_rdata <= {24'h000000,
					rx_pop_valid ? rx_pop_data : 8'h00};
				`ULFC_STAT_OFF: reg_rdata <= {24'h000000, ovr_q, ferr_q,
					perr_q, tx_st_q != TX_IDLE, !rx_pop_valid,
					!rx_push_ready, !tx_pop_valid, !tx_push_ready};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	sequence s_last_stop;
		tx_st_q == TX_STOP && tx_tick && !tx_stop2_q;
	endsequence

	sequence s_data_end;
		tx_st_q == TX_DATA && tx_tick && tx_last;
	endsequence

	chk_break_line_low: assert property (
		tx_st_q == TX_BRK |=> !serial_tx_out)
		else $error("line not low during break");
	chk_break_waits_frame: assert property (
		tx_st_q == TX_DATA && send_break |=> tx_st_q != TX_BRK)
		else $error("break cut a frame short");
	chk_start_bit_low: assert property (
		tx_st_q == TX_START |=> !serial_tx_out)
		else $error("start bit not low");
	chk_two_stop_bits: assert property (
		s_last_stop ##0 two_stop_sel |=> tx_st_q == TX_STOP [*2])
		else $error("second stop bit missing");
	chk_one_stop_bit: assert property (
		s_last_stop ##0 !two_stop_sel |=> tx_st_q == TX_IDLE)
		else $error("extra stop bit sent");
	chk_parity_skip: assert property (
		s_data_end ##0 !parity_on |=> tx_st_q == TX_STOP)
		else $error("parity slot sent while parity off");
	chk_parity_slot: assert property (
		s_data_end ##0 parity_on |=> tx_st_q == TX_PAR)
		else $error("parity slot missing");
	chk_stick_value: assert property (
		tx_st_q == TX_PAR && stick_parity_sel && $stable(lcr_q)
		|=> serial_tx_out == !even_parity_sel)
		else $error("stick parity value wrong");
	chk_even_count: assert property (
		tx_st_q == TX_PAR && !stick_parity_sel && even_parity_sel &&
		$stable(lcr_q) |=> !(^{serial_tx_out,
		tx_word_q & word_mask(word_length_sel)}))
		else $error("even parity wrong");
	chk_char_depth: assert property (
		!fifo_mode_on |-> tx_level <= 1 && rx_level <= 1)
		else $error("character mode holds more than one");
	chk_rx_one_stop: assert property (
		rx_st_q == RX_STOP && rx_tick && rx_s2_q
		|=> rx_st_q == RX_IDLE && rx_push_q)
		else $error("receiver did not finish on one stop bit");
	chk_rx_parity_flag: assert property (
		perr_set |=> perr_q)
		else $error("parity error not flagged");
endmodule // ulfc_top

/* File: verification/ulfc_peer.sv */
// far-side serial peer: sends frames and captures frames
`timescale 1ns/10ps
module ulfc_peer #(
	parameter int BIT_CYC = 8
) (
	// clock
	input wire logic clk,
	// serial line
	input wire logic line_in,
	output logic line_out
);
	initial line_out = 1'b1;
	////////////////////////////////////////////////////////////////////////
	// f holds start, data, parity and stop bits, sent from bit 0 up
	task automatic send(input logic [11:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			repeat (BIT_CYC) begin
				@(posedge clk);
				line_out <= f[i];
			end
		end
		// line back to idle high; the stop bits sent are those in f
		@(posedge clk);
		line_out <= 1'b1;
	endtask
	// sampled on the falling edge so the registered pin is settled
	task automatic grab(input int n, output logic [11:0] f);
		int t;
		f = '1;
		t = 0;
		while (line_in !== 1'b0 && t < 4000) begin
			@(negedge clk);
			t++;
		end
		repeat (BIT_CYC / 2) @(negedge clk);
		// return mid last bit so a queued next start is not missed
		for (int i = 0; i < n; i++) begin
			if (i > 0) begin
				repeat (BIT_CYC) @(negedge clk);
			end
			f[i] = line_in;
		end
	endtask
endmodule // ulfc_peer

/* File: verification/ulfc_top_test.sv */
// self-checking bench for the line-format block
`timescale 1ns/10ps
module ulfc_top_test;
	localparam int BC = 8;
	typedef struct {
		logic [7:0] lcr;
		logic [7:0] d;
		int n;
	} ulfc_row_t;
	logic clk, rst_b, reg_wr, reg_rd, serial_rx_in, serial_tx_out;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv, cnt;
	logic [11:0] ef, gf;
	int n_mismatch, num_checks, n;
	int cyc = 0;
	ulfc_row_t rows [10] = '{
		'{8'h10, 8'h15, 7}, '{8'h30, 8'h2A, 8}, '{8'h50, 8'h5B, 9},
		'{8'h70, 8'hA5, 10}, '{8'h76, 8'hB1, 11}, '{8'h72, 8'hB1, 11},
		'{8'hF6, 8'hFF, 11}, '{8'hF2, 8'h00, 11}, '{8'h7C, 8'h3C, 11},
		'{8'h5A, 8'h7F, 11}
	};
	logic [7:0] mode [2] = '{8'h78, 8'h60};

	ulfc_top #(.BIT_CYC(BC), .DEPTH(32)) dut_u (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .serial_rx_in(serial_rx_in),
		.serial_tx_out(serial_tx_out)
	);
	ulfc_peer #(.BIT_CYC(BC)) peer_u (
		.clk(clk), .line_in(serial_tx_out), .line_out(serial_rx_in)
	);

	initial clk = 1'b0;
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	// expected frame for a line setting, stop bits left at 1
	function automatic int mk(input logic [7:0] lcr, input logic [7:0] d,
		output logic [11:0] f);
		int nb;
		int k;
		logic p;
		nb = 5 + lcr[6:5];
		f = '1;
		f[0] = 1'b0;
		p = 1'b0;
		for (int i = 0; i < nb; i++) begin
			f[i + 1] = d[i];
			p = p ^ d[i];
		end
		k = nb + 1;
		if (lcr[1]) begin
			f[k] = lcr[7] ? ~lcr[2] : (lcr[2] ? p : ~p);
			k++;
		end
		return k + 1 + lcr[3];
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		d = reg_rdata;
	endtask
	task automatic ones(input int c, output logic [31:0] k);
		k = '0;
		repeat (c) begin
			@(negedge clk);
			k = k + serial_tx_out;
		end
	endtask
	task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task automatic chk_frame(input logic [11:0] g, input logic [11:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t frame %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up;
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// the whole run needs a few thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			wrap_up;
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = '0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		chk_reg({31'h0, serial_tx_out}, 32'h1);
		chk_reg(reg_rdata, 32'h0);
		rst_b <= 1'b1;
		rd(8'h00, rv);
		chk_reg(rv, 32'h0);
		rd(8'h3C, rv);
		chk_reg(rv, 32'h0);
		rd(8'h08, rv);
		chk_reg(rv, 32'h0A);
		foreach (rows[i]) begin
			wr(8'h00, {24'h0, rows[i].lcr});
			rd(8'h00, rv);
			chk_reg(rv, {24'h0, rows[i].lcr});
			wr(8'h04, {24'h0, rows[i].d});
			n = mk(rows[i].lcr, rows[i].d, ef);
			peer_u.grab(rows[i].n, gf);
			chk_frame(gf, ef);
			// still busy in the last stop bit: a short frame would be idle
			rd(8'h08, rv);
			chk_reg(rv & 32'h10, 32'h10);
			repeat (BC) @(posedge clk);
			n = mk(rows[i].lcr & 8'hF7, rows[i].d, ef);
			peer_u.send(ef, n);
			repeat (2) @(posedge clk);
			rd(8'h04, rv);
			chk_reg(rv, {24'h0, rows[i].d & ((8'h1 << n - 2 -
				rows[i].lcr[1]) - 8'h1)});
			rd(8'h08, rv);
			chk_reg(rv & 32'hE0, 32'h0);
		end
		// bad parity, then a low stop bit
		wr(8'h00, 32'h76);
		for (int j = 0; j < 2; j++) begin
			wr(8'h08, 32'hE0);
			n = mk(8'h76, 8'h5A, ef);
			peer_u.send(ef ^ (j ? 12'h400 : 12'h200), n);
			repeat (2) @(posedge clk);
			rd(8'h08, rv);
			chk_reg(rv & 32'h60, j ? 32'h40 : 32'h20);
		end
		// queued against single-character holding, both directions
		wr(8'h00, 32'h60);
		foreach (mode[m]) begin
			wr(8'h00, {24'h0, mode[m]});
			fork
				for (int j = 0; j < 3; j++) wr(8'h04, 32'hA0 + j);
				for (int j = 0; j < 3 - m; j++) begin
					n = mk(mode[m], 8'hA0 + 8'(j), ef);
					peer_u.grab(n, gf);
					chk_frame(gf, ef);
				end
			join
			ones(12 * BC, cnt);
			chk_reg(cnt, 12 * BC);
			wr(8'h08, 32'hE0);
			for (int j = 0; j < 2; j++) begin
				// one stop bit back to back, even with two selected
				n = mk(mode[m] & 8'hF7, 8'hC0 + 8'(j), ef);
				peer_u.send(ef, n);
			end
			repeat (2) @(posedge clk);
			rd(8'h08, rv);
			chk_reg(rv, m ? 32'h86 : 32'h02);
			rd(8'h04, rv);
			chk_reg(rv, 32'hC0);
			rd(8'h04, rv);
			chk_reg(rv, m ? 32'h0 : 32'hC1);
			rd(8'h08, rv);
			chk_reg(rv & 32'h80, m ? 32'h80 : 32'h0);
		end
		// break raised mid-character must wait for its stop bit
		wr(8'h00, 32'h70);
		wr(8'h04, 32'h96);
		n = mk(8'h70, 8'h96, ef);
		fork
			peer_u.grab(n, gf);
			begin
				repeat (3 * BC) @(posedge clk);
				wr(8'h00, 32'h71);
			end
		join
		chk_frame(gf, ef);
		repeat (BC) @(posedge clk);
		ones(20 * BC, cnt);
		chk_reg(cnt, 32'h0);
		wr(8'h00, 32'h70);
		repeat (3) @(negedge clk);
		chk_reg({31'h0, serial_tx_out}, 32'h1);
		wrap_up;
	end
endmodule // ulfc_top_test
